// ---- timing_pkg.sv ----
package timing_pkg;

   localparam int unsigned WORD_W = 32;
   localparam int unsigned CNT_W  = 6;

   // ********************************
   // opcode fields
   // ********************************
   localparam int unsigned OP_MSB     = 31;
   localparam int unsigned OP_LSB     = 26;
   localparam int unsigned PFX3_LSB   = 29;
   localparam int unsigned PFX2_LSB   = 30;
   localparam int unsigned PFX5_LSB   = 27;
   localparam logic [2:0]  LCS_PREFIX  = 3'h5;
   localparam logic [1:0]  CJMP_PREFIX = 2'h3;
   localparam logic [4:0]  JUMP_PREFIX = 5'h10;

   localparam logic [5:0] OP_LOAD_CONSTANT_LONG = 6'h01;
   localparam logic [5:0] OP_HALT_WAIT          = 6'h02;
   localparam logic [5:0] OP_WORD_LOAD          = 6'h08;
   localparam logic [5:0] OP_UBYTE_LOAD         = 6'h0a;
   localparam logic [5:0] OP_SBYTE_LOAD         = 6'h0b;
   localparam logic [5:0] OP_WORD_STORE         = 6'h0c;
   localparam logic [5:0] OP_BYTE_STORE         = 6'h0e;
   localparam logic [5:0] OP_MULTIPLY           = 6'h12;
   localparam logic [5:0] OP_UDIVIDE            = 6'h14;
   localparam logic [5:0] OP_SDIVIDE            = 6'h15;
   localparam logic [5:0] OP_UMODULO            = 6'h16;
   localparam logic [5:0] OP_SMODULO            = 6'h17;
   localparam logic [5:0] OP_SHIFT_LEFT         = 6'h1c;
   localparam logic [5:0] OP_SHIFT_RIGHT_U      = 6'h1e;
   localparam logic [5:0] OP_SHIFT_RIGHT_S      = 6'h1f;

   // short constant: value[20:16] in word[28:24], value[15:0] in word[15:0]
   localparam int unsigned SC_HI_MSB = 28;
   localparam int unsigned SC_HI_LSB = 24;
   localparam int unsigned SC_LO_MSB = 15;
   localparam int unsigned SC_EXT_W  = 11;

   // ********************************
   // cycle counts
   // ********************************
   localparam logic [CNT_W-1:0] CYC_ONE        = 6'h01;
   localparam logic [CNT_W-1:0] CYC_TWO        = 6'h02;
   localparam logic [CNT_W-1:0] CYC_JUMP       = 6'h04;
   localparam logic [CNT_W-1:0] CYC_BR_TAKEN   = 6'h05;
   localparam logic [CNT_W-1:0] CYC_BR_NOT     = 6'h02;
   localparam logic [CNT_W-1:0] CYC_LOAD_MIN   = 6'h03;
   localparam logic [CNT_W-1:0] CYC_STORE_MIN  = 6'h02;
   localparam logic [CNT_W-1:0] CYC_DIV        = 6'h24;
   localparam logic [CNT_W-1:0] CYC_MOD        = 6'h25;
   localparam logic [CNT_W-1:0] CYC_MUL_DEF    = 6'h02;

   localparam logic [WORD_W-1:0] ADDR_MASK  = 32'hffff_fffc;
   localparam logic [WORD_W-1:0] START_DEF  = 32'h0000_0000;

   typedef enum logic [3:0] {
      CLS_ALU, CLS_LCS, CLS_LC, CLS_SHIFT, CLS_JUMP, CLS_BRANCH,
      CLS_LOAD, CLS_STORE, CLS_MUL, CLS_DIV, CLS_MOD, CLS_HALT
   } cls_e;

   typedef enum logic [2:0] {
      ST_READY = 3'h1,
      ST_BUSY  = 3'h2,
      ST_HALT  = 3'h4
   } state_e;

   typedef struct packed {
      logic              valid;
      logic [WORD_W-1:0] word;
      logic              taken;
      logic [WORD_W-1:0] target;
   } issue_s;

   typedef struct packed {
      logic done;
      logic redirect;
      logic zero_result;
   } retire_s;

endpackage

// ---- cycle_counter.sv ----
`timescale 1ns/1ns
`default_nettype none
module cycle_counter import timing_pkg::*; #(
   parameter int unsigned W = CNT_W
) (
   input  wire logic         clock,
   input  wire logic         nrst,
   input  wire logic         load,
   input  wire logic [W-1:0] load_value,
   input  wire logic         dec,
   output var  logic [W-1:0] count
);

   typedef struct packed {
      logic [W-1:0] count;
   } ctr_s;

   ctr_s cur;
   ctr_s next_cur;

   always_comb begin
      next_cur = cur;
      if (load) begin
         next_cur.count = load_value;
      end else if (dec) begin
         next_cur.count = cur.count - W'(1);
      end
   end

   always_ff @(posedge clock) begin
      if (!nrst) begin
         cur <= '0;
      end else begin
         cur <= next_cur;
      end
   end

   assign count = cur.count;

endmodule
`default_nettype wire

// ---- instruction_timing.sv ----
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// - counts hold only without fetch stalls; a stall freezes the countdown.
// - conditional jump takes 5 cycles when taken, 2 when not.
// - loads take at least 3 cycles, stores 2, plus data-bus acknowledge wait.
// - multiply takes 2, 6 or 34 cycles, fixed by configuration.
// - short constant load is one word, one cycle, sign-extends 21 bits.
// - start address is 32 bits; its two low bits are dropped.
// - divide takes 36 cycles, modulo 37.
// - register jump, call, return and interrupt return take 4 cycles.
// - long constant and shifts take 2 cycles; simple operations take 1.
// - without a divider, divide and modulo write zero.
// - halt waits for an interrupt with no fixed count.
module instruction_timing import timing_pkg::*; #(
   parameter logic [WORD_W-1:0] START_ADDR  = START_DEF,
   parameter logic [CNT_W-1:0]  MUL_CYCLES  = CYC_MUL_DEF,
   parameter bit                HAS_DIVIDER = 1'b1
) (
   input  wire logic              clock,
   input  wire logic              nrst,
   input  wire issue_s            issue,
   input  wire logic              fetch_stall,
   input  wire logic              dbus_ack,
   input  wire logic              irq_pin,
   output var  logic              ready,
   output var  retire_s           retire,
   output var  logic [WORD_W-1:0] imm_value,
   output var  logic [WORD_W-1:0] fetch_base,
   output var  logic              halted
);

   // ********************************
   // decode
   // ********************************
   function automatic cls_e class_of(input logic [WORD_W-1:0] w);
      cls_e c;
      c = CLS_ALU;
      if (w[OP_MSB:PFX3_LSB] == LCS_PREFIX) begin
         c = CLS_LCS;
      end else if (w[OP_MSB:PFX2_LSB] == CJMP_PREFIX) begin
         c = CLS_BRANCH;
      end else if (w[OP_MSB:PFX5_LSB] == JUMP_PREFIX) begin
         c = CLS_JUMP;
      end else begin
         case (w[OP_MSB:OP_LSB])
            OP_LOAD_CONSTANT_LONG: c = CLS_LC;
            OP_HALT_WAIT:          c = CLS_HALT;
            OP_WORD_LOAD, OP_UBYTE_LOAD, OP_SBYTE_LOAD: c = CLS_LOAD;
            OP_WORD_STORE, OP_BYTE_STORE:               c = CLS_STORE;
            OP_MULTIPLY:           c = CLS_MUL;
            OP_UDIVIDE, OP_SDIVIDE: c = CLS_DIV;
            OP_UMODULO, OP_SMODULO: c = CLS_MOD;
            OP_SHIFT_LEFT, OP_SHIFT_RIGHT_U, OP_SHIFT_RIGHT_S: c = CLS_SHIFT;
            default:               c = CLS_ALU;
         endcase
      end
      return c;
   endfunction

   function automatic logic [CNT_W-1:0] cycles_of(input cls_e c, input logic taken);
      logic [CNT_W-1:0] n;
      n = CYC_ONE;
      unique case (c)
         CLS_LC, CLS_SHIFT: n = CYC_TWO;
         CLS_JUMP:          n = CYC_JUMP;
         CLS_BRANCH:        n = taken ? CYC_BR_TAKEN : CYC_BR_NOT;
         CLS_LOAD:          n = CYC_LOAD_MIN;
         CLS_STORE:         n = CYC_STORE_MIN;
         CLS_MUL:           n = MUL_CYCLES;
         CLS_DIV:           n = CYC_DIV;
         CLS_MOD:           n = CYC_MOD;
         CLS_ALU, CLS_LCS, CLS_HALT: n = CYC_ONE;
      endcase
      return n;
   endfunction

   function automatic logic [WORD_W-1:0] short_const(input logic [WORD_W-1:0] w);
      return {{SC_EXT_W{w[SC_HI_MSB]}}, w[SC_HI_MSB:SC_HI_LSB], w[SC_LO_MSB:0]};
   endfunction

   // ********************************
   // state
   // ********************************
   typedef struct packed {
      state_e            st;
      cls_e              cls;
      logic              taken;
      logic [WORD_W-1:0] target;
      logic              ack_seen;
      logic [2:0]        irq_sync;
      logic              irq_level;
      logic              ready;
      retire_s           ret;
      logic [WORD_W-1:0] imm;
      logic [WORD_W-1:0] fetch;
      logic              halted;
   } core_s;

   // the start address is a constant, so the reset value stays a constant
   localparam core_s RESET_STATE = '{st: ST_READY, cls: CLS_ALU, taken: 1'b0, target: '0,
                                     ack_seen: 1'b0, irq_sync: '0, irq_level: 1'b0,
                                     ready: 1'b1, ret: '0, imm: '0,
                                     fetch: START_ADDR & ADDR_MASK, halted: 1'b0};

   core_s            cur;
   core_s            next_cur;
   logic             ctr_load;
   logic [CNT_W-1:0] ctr_value;
   logic             ctr_dec;
   logic [CNT_W-1:0] count;

   cycle_counter #(.W(CNT_W)) u_counter (
      .clock      (clock),
      .nrst       (nrst),
      .load       (ctr_load),
      .load_value (ctr_value),
      .dec        (ctr_dec),
      .count      (count)
   );

   always_comb begin
      cls_e             c;
      logic [CNT_W-1:0] n;
      logic             fin;
      logic             mem;
      c         = class_of(issue.word);
      n         = cycles_of(c, issue.taken);
      fin       = 1'b0;
      mem       = (cur.cls == CLS_LOAD) || (cur.cls == CLS_STORE);
      next_cur  = cur;
      ctr_load  = 1'b0;
      ctr_value = '0;
      ctr_dec   = 1'b0;
      next_cur.ret      = '0;
      next_cur.irq_sync = {cur.irq_sync[1:0], irq_pin};
      // interrupt line counts once the second and third stages agree
      if (cur.irq_sync[2] == cur.irq_sync[1]) begin
         next_cur.irq_level = cur.irq_sync[2];
      end
      unique case (cur.st)
         ST_READY: begin
            if (issue.valid) begin
               next_cur.cls      = c;
               next_cur.taken    = issue.taken;
               next_cur.target   = issue.target;
               next_cur.ack_seen = 1'b0;
               if (c == CLS_LCS) begin
                  next_cur.imm = short_const(issue.word);
               end
               if (c == CLS_HALT) begin
                  next_cur.st     = ST_HALT;
                  next_cur.ready  = 1'b0;
                  next_cur.halted = 1'b1;
               end else if (n == CYC_ONE) begin
                  fin = 1'b1;
               end else begin
                  next_cur.st    = ST_BUSY;
                  next_cur.ready = 1'b0;
                  ctr_load       = 1'b1;
                  ctr_value      = n - CYC_ONE;
               end
            end
         end
         ST_BUSY: begin
            if (dbus_ack) begin
               next_cur.ack_seen = 1'b1;
            end
            // a fetch stall freezes the count, so the instruction runs longer
            if (!fetch_stall) begin
               if (count == CYC_ONE) begin
                  // memory access also waits for the data-bus acknowledge
                  if (!mem || cur.ack_seen || dbus_ack) begin
                     fin = 1'b1;
                  end
               end else begin
                  ctr_dec = 1'b1;
               end
            end
         end
         ST_HALT: begin
            if (cur.irq_level) begin
               fin = 1'b1;
            end
         end
      endcase
      if (fin) begin
         next_cur.st       = ST_READY;
         next_cur.ready    = 1'b1;
         next_cur.halted   = 1'b0;
         next_cur.ret.done = 1'b1;
         next_cur.ret.redirect = (next_cur.cls == CLS_JUMP) ||
                                 ((next_cur.cls == CLS_BRANCH) && next_cur.taken);
         if (next_cur.ret.redirect) begin
            next_cur.fetch = next_cur.target & ADDR_MASK;
         end
         next_cur.ret.zero_result = !HAS_DIVIDER &&
                                    ((next_cur.cls == CLS_DIV) || (next_cur.cls == CLS_MOD));
      end
   end

   always_ff @(posedge clock) begin
      if (!nrst) begin
         cur <= RESET_STATE;
      end else begin
         cur <= next_cur;
      end
   end

   assign ready      = cur.ready;
   assign retire     = cur.ret;
   assign imm_value  = cur.imm;
   assign fetch_base = cur.fetch;
   assign halted     = cur.halted;

   // ********************************
   // checks
   // ********************************
   logic        take;
   cls_e        h_cls;
   logic        h_taken;
   logic        h_clean;
   logic [15:0] h_elapsed;

   assign take = issue.valid && (cur.st == ST_READY);

   always_ff @(posedge clock) begin
      if (!nrst) begin
         h_cls     <= CLS_ALU;
         h_taken   <= 1'b0;
         h_clean   <= 1'b1;
         h_elapsed <= '0;
      end else if (take) begin
         h_cls     <= class_of(issue.word);
         h_taken   <= issue.taken;
         h_clean   <= 1'b1;
         h_elapsed <= 16'h0001;
      end else if (cur.st != ST_READY) begin
         h_elapsed <= h_elapsed + 16'h0001;
         if (fetch_stall) begin
            h_clean <= 1'b0;
         end
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (!nrst);

   sequence s_take(cls_e k);
      take && (class_of(issue.word) == k);
   endsequence

   sequence s_done(cls_e k);
      retire.done && h_clean && (h_cls == k);
   endsequence

   a_alu_single: assert property (s_take(CLS_ALU) |=> retire.done)
      else $error("simple operation did not retire in one cycle");
   a_lc_two: assert property (s_take(CLS_LC) ##1 !fetch_stall |-> ##1 retire.done)
      else $error("long constant did not retire in two cycles");
   a_shift_two: assert property (s_take(CLS_SHIFT) |=> !retire.done ##0 !ready)
      else $error("shift retired too early");
   a_lcs_value: assert property (s_take(CLS_LCS) |=> retire.done && (imm_value == short_const($past(issue.word))))
      else $error("short constant wrong or late");
   a_jump_four: assert property (s_done(CLS_JUMP) |-> h_elapsed == 16'(CYC_JUMP) && retire.redirect)
      else $error("jump count wrong");
   a_branch_len: assert property (s_done(CLS_BRANCH) |->
                                  h_elapsed == 16'(h_taken ? CYC_BR_TAKEN : CYC_BR_NOT))
      else $error("conditional jump count wrong");
   a_div_len: assert property (s_done(CLS_DIV) |-> h_elapsed == 16'(CYC_DIV))
      else $error("divide count wrong");
   a_mod_len: assert property (s_done(CLS_MOD) |-> h_elapsed == 16'(CYC_MOD))
      else $error("modulo count wrong");
   a_mul_len: assert property (s_done(CLS_MUL) |-> h_elapsed == 16'(MUL_CYCLES))
      else $error("multiply count wrong");
   a_load_min: assert property (retire.done && (h_cls == CLS_LOAD) |-> h_elapsed >= 16'(CYC_LOAD_MIN))
      else $error("load too short");
   a_store_min: assert property (retire.done && (h_cls == CLS_STORE) |-> h_elapsed >= 16'(CYC_STORE_MIN))
      else $error("store too short");
   a_start_addr: assert property ($rose(nrst) |-> fetch_base == (START_ADDR & ADDR_MASK))
      else $error("start address not aligned");
   a_div_zero: assert property (retire.done && ((h_cls == CLS_DIV) || (h_cls == CLS_MOD)) |->
                                retire.zero_result == !HAS_DIVIDER)
      else $error("zero result flag wrong");
   a_halt_hold: assert property ((cur.st == ST_HALT) && !cur.irq_level |=> !retire.done)
      else $error("halt left without interrupt");
   a_stall_hold: assert property ((cur.st == ST_BUSY) && fetch_stall |=> $stable(count))
      else $error("count moved during stall");

endmodule
`default_nettype wire

// ---- dbus_responder.sv ----
`timescale 1ns/1ns
`default_nettype none
// ****************************
// data memory acknowledge model
// ****************************
module dbus_responder (
   input  wire logic       clock,
   input  wire logic       nrst,
   input  wire logic       req,
   input  wire logic [3:0] lat,
   output var  logic       ack
);
   logic [3:0] cnt;

   // one ack pulse lat cycles after the request; a slow memory is just a larger lat
   always_ff @(posedge clock) begin
      if (!nrst) begin
         cnt <= 4'h0;
      end else if (req) begin
         cnt <= lat;
      end else if (cnt != 4'h0) begin
         cnt <= cnt - 4'h1;
      end
   end

   // ack stands one cycle unless a req with lat 1 arrives while ack is high, so a missed capture shows as a hang
   assign ack = (cnt == 4'h1);
endmodule
`default_nettype wire

// ---- test_instruction_timing.sv ----
`timescale 1ns/1ns
`default_nettype none
module test_instruction_timing import timing_pkg::*;;
   localparam logic [31:0] START = 32'h0000_1237;
   localparam logic [31:0] TGT   = 32'h0000_4567;

   logic              clock;
   logic              nrst;
   issue_s            issue;
   logic              fetch_stall;
   logic              dbus_ack;
   logic              irq_pin;
   logic              ready;
   retire_s           retire;
   logic [WORD_W-1:0] imm_value;
   logic [WORD_W-1:0] fetch_base;
   logic              halted;
   logic              req;
   logic [3:0]        lat;
   int                n_fail;
   int                check_count;

   // ****************************
   // design and memory model
   // ****************************
   // no divider, so div/mod also exercise the zero result path
   instruction_timing #(
      .START_ADDR (START),
      .MUL_CYCLES (6'h06),
      .HAS_DIVIDER(1'b0)
   ) uut (
      .clock      (clock),
      .nrst       (nrst),
      .issue      (issue),
      .fetch_stall(fetch_stall),
      .dbus_ack   (dbus_ack),
      .irq_pin    (irq_pin),
      .ready      (ready),
      .retire     (retire),
      .imm_value  (imm_value),
      .fetch_base (fetch_base),
      .halted     (halted)
   );

   dbus_responder mem (
      .clock(clock),
      .nrst (nrst),
      .req  (req),
      .lat  (lat),
      .ack  (dbus_ack)
   );

   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end

   // ****************************
   // checking
   // ****************************
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic print_verdict;
      $display("checks %0d, mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // issue one instruction, count cycles to done, judge the retire flags
   task automatic run(input logic [31:0] w, input logic tk, input int lt, input int st,
                      input int exp_n, input logic rd, input logic z);
      int n;
      @(posedge clock);
      issue <= '{valid: 1'b1, word: w, taken: tk, target: TGT};
      req <= (lt > 0);
      lat <= 4'(lt);
      @(posedge clock);
      issue.valid <= 1'b0;
      req <= 1'b0;
      fetch_stall <= (st > 0);
      n = 1;
      #1;
      check(32'(ready), 32'(exp_n == 1));
      while (retire.done !== 1'b1 && n < 100) begin
         @(posedge clock);
         fetch_stall <= (n < st);
         #1;
         n++;
      end
      check(32'(n), 32'(exp_n));
      check(32'(ready), 32'(exp_n < 100));
      check(32'(retire.redirect), 32'(rd));
      check(32'(retire.zero_result), 32'(z));
      if (rd) check(fetch_base, TGT & 32'hffff_fffc);
   endtask

   task automatic halt_wake;
      int n;
      run(32'h0800_0000, 1'b0, 0, 0, 100, 1'b0, 1'b0);
      check(32'(halted), 32'h1);
      check(32'(ready), 32'h0);
      @(posedge clock);
      irq_pin <= 1'b1;
      n = 0;
      #1;
      while (retire.done !== 1'b1 && n < 10) begin
         @(posedge clock);
         #1;
         n++;
      end
      check(32'(n < 10), 32'h1);
      check(32'(halted), 32'h0);
      @(posedge clock);
      irq_pin <= 1'b0;
   endtask

   // ****************************
   // scenarios
   // ****************************
   task automatic simple_ops;
      run(32'h4602_0105, 1'b0, 0, 0, 1, 1'b0, 1'b0);
      run(32'h6602_013f, 1'b0, 0, 0, 1, 1'b0, 1'b0);
      run(32'h6a02_013f, 1'b0, 0, 0, 1, 1'b0, 1'b0);
      run(32'h0000_0000, 1'b0, 0, 0, 1, 1'b0, 1'b0);
   endtask

   // long constant and shifts, one shift stretched by a fetch stall
   task automatic multi_cycle;
      run(32'h0401_0000, 1'b0, 0, 0, 2, 1'b0, 1'b0);
      run(32'h7202_0105, 1'b0, 0, 0, 2, 1'b0, 1'b0);
      run(32'h7e02_0105, 1'b0, 0, 0, 2, 1'b0, 1'b0);
      run(32'h7a02_0105, 1'b0, 0, 2, 4, 1'b0, 1'b0);
   endtask

   task automatic short_constants;
      run(32'hb001_bdc0, 1'b0, 0, 0, 1, 1'b0, 1'b0);
      check(imm_value, 32'hfff0_bdc0);
      run(32'haf01_ffff, 1'b0, 0, 0, 1, 1'b0, 1'b0);
      check(imm_value, 32'h000f_ffff);
   endtask

   task automatic transfers;
      run(32'h8200_0100, 1'b0, 0, 0, 4, 1'b1, 1'b0);
      run(32'h8600_0100, 1'b0, 0, 0, 4, 1'b1, 1'b0);
      run(32'hea02_0105, 1'b1, 0, 0, 5, 1'b1, 1'b0);
      run(32'hea02_0105, 1'b0, 0, 0, 2, 1'b0, 1'b0);
   endtask

   task automatic arith;
      run(32'h4a02_0103, 1'b0, 0, 0, 6, 1'b0, 1'b0);
      run(32'h5602_01fd, 1'b0, 0, 0, 36, 1'b0, 1'b1);
      run(32'h5202_0107, 1'b0, 0, 3, 39, 1'b0, 1'b1);
      run(32'h5e02_010a, 1'b0, 0, 0, 37, 1'b0, 1'b1);
      run(32'h5a02_010a, 1'b0, 0, 0, 37, 1'b0, 1'b1);
   endtask

   // acknowledge early, on time and late against the load minimum; on time and late against the store minimum
   task automatic memory_ops;
      run(32'h2e02_0100, 1'b0, 1, 0, 3, 1'b0, 1'b0);
      run(32'h2a02_0100, 1'b0, 2, 0, 3, 1'b0, 1'b0);
      run(32'h2202_0100, 1'b0, 5, 0, 6, 1'b0, 1'b0);
      run(32'h3b00_0201, 1'b0, 1, 0, 2, 1'b0, 1'b0);
      run(32'h3300_0201, 1'b0, 4, 0, 5, 1'b0, 1'b0);
   endtask

   // a reset in the middle of a divide must drop all held state
   task automatic reset_mid_run;
      @(posedge clock);
      issue <= '{valid: 1'b1, word: 32'h5602_01fd, taken: 1'b0, target: TGT};
      @(posedge clock);
      issue.valid <= 1'b0;
      repeat (4) @(posedge clock);
      nrst <= 1'b0;
      repeat (2) @(posedge clock);
      nrst <= 1'b1;
      #1;
      check(32'(ready), 32'h1);
      check(32'(retire), 32'h0);
      check(32'(halted), 32'h0);
      check(imm_value, 32'h0);
      check(fetch_base, START & 32'hffff_fffc);
      run(32'h7202_0105, 1'b0, 0, 0, 2, 1'b0, 1'b0);
   endtask

   // ****************************
   // main sequence
   // ****************************
   initial begin
      n_fail = 0;
      check_count = 0;
      nrst = 1'b0;
      issue = '0;
      fetch_stall = 1'b0;
      irq_pin = 1'b0;
      req = 1'b0;
      lat = 4'h0;
      repeat (6) @(posedge clock);
      nrst <= 1'b1;
      @(posedge clock);
      #1;
      check(fetch_base, START & 32'hffff_fffc);
      check(32'(ready), 32'h1);
      check(imm_value, 32'h0);
      simple_ops;
      multi_cycle;
      short_constants;
      transfers;
      arith;
      memory_ops;
      reset_mid_run;
      halt_wake;
      print_verdict;
   end

   // whole run is well under 2000 cycles
   initial begin
      #3000000;
      n_fail++;
      $display("mismatch at %0t: timeout", $time);
      print_verdict;
   end
endmodule
`default_nettype wire
